//--- design/flipc_top.sv
// Purpose: seven source, four level nested interrupt controller with apb registers
// Assumes: request flags are levels held by the peripherals until cleared
// Notes: core takes the vector with irqAck and ends a service with irqReturn
//
// The APB interface to the registers was left to the implementer.
module flipc_top #(
  parameter bit HAS_CA = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flipc_pkg::ADDR_W-1:0] paddr,
  input wire logic [flipc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [flipc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] reqFlags,
  input wire logic ext0EdgeMode,
  input wire logic ext1EdgeMode,
  input wire logic irqAck,
  input wire logic irqReturn,
  output logic irqReq,
  output logic [7:0] irqVector,
  output logic [6:0] flagClear
);
  import flipc_pkg::*;

  // ==========================================================
  // state
  logic [7:0] interruptEnableReg;
  logic [7:0] priorityHighReg;
  logic [7:0] priorityLowReg;
  logic [3:0] inService;
  flipc_state_t state;
  flipc_src_t offerSrc;
  flipc_level_t offerLevel;
  logic [7:0] implMask;
  logic accessPhase;
  logic writeNow;
  logic addrHit;
  logic [7:0] next_read;
  logic taken;
  logic [3:0] next_inService;
  logic [6:0] next_clear;

  flipc_arb_if arb ();

  flipc_arbiter u_arbiter (
    .clk(clk),
    .reset_n(reset_n),
    .arb(arb)
  );

  // counter array bit exists only on the larger variant
  assign implMask = HAS_CA ? 8'h7f : 8'h3f; // R1 R12

  // ==========================================================
  // apb slave
  // one cycle setup, zero wait access; answers are registered at the setup edge
  assign accessPhase = psel && penable && pready;
  assign writeNow = accessPhase && pwrite && pstrb[0] && !pslverr;

  always_comb begin
    next_read = 8'h00;
    addrHit = 1'b1;
    case (paddr)
      ADDR_ENABLE: next_read = interruptEnableReg;
      ADDR_PRIO_HIGH: next_read = priorityHighReg;
      ADDR_PRIO_LOW: next_read = priorityLowReg;
      ADDR_STATUS: next_read = {irqReq, offerSrc[2:0], inService};
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable; // R2
      pslverr <= psel && !penable && !addrHit;
      if (psel && !penable && !pwrite) begin
        if (paddr == ADDR_STATUS) begin
          prdata <= {21'h0, offerSrc, 3'h0, irqReq, inService};
        end else begin
          prdata <= {24'h000000, next_read};
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interruptEnableReg <= RST_ENABLE;
      priorityHighReg <= RST_PRIO;
      priorityLowReg <= RST_PRIO;
    end else if (writeNow) begin
      case (paddr)
        ADDR_ENABLE: interruptEnableReg <= pwdata[7:0] & (implMask | 8'h80); // R2 R11
        ADDR_PRIO_HIGH: priorityHighReg <= pwdata[7:0] & implMask; // R2
        ADDR_PRIO_LOW: priorityLowReg <= pwdata[7:0] & implMask; // R12
        default: ;
      endcase
    end
  end

  // ==========================================================
  // request gating
  always_comb begin
    arb.pend = reqFlags & interruptEnableReg[6:0] & implMask[6:0]
      & {7{interruptEnableReg[BIT_GLOBAL]}}; // R10 R11
    arb.prioHigh = priorityHighReg[6:0];
    arb.prioLow = priorityLowReg[6:0];
    arb.inService = inService;
  end

  // ==========================================================
  // dispatch sequencer
  // two settle cycles let the flag clear and the new level reach the arbiter
  assign taken = (state == ST_OFFER) && irqAck;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      offerSrc <= 3'h0;
      offerLevel <= 2'h0;
      irqReq <= 1'b0;
      irqVector <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (arb.winValid) begin
            state <= ST_OFFER; // R4
            offerSrc <= arb.winSrc;
            offerLevel <= arb.winLevel;
            irqReq <= 1'b1;
            irqVector <= VEC_TABLE[arb.winSrc]; // R8
          end
        end
        ST_OFFER: begin
          if (irqAck) begin
            state <= ST_SETTLE_A;
            irqReq <= 1'b0;
          end
        end
        ST_SETTLE_A: state <= ST_SETTLE_B;
        ST_SETTLE_B: state <= ST_IDLE;
        default: begin
          state <= ST_IDLE;
          irqReq <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // in-service tracking
  // a return always closes the highest open level, so nesting unwinds in order
  always_comb begin
    next_inService = inService;
    if (irqReturn) begin
      next_inService = next_inService & ~topOneHot(inService); // R7
    end
    if (taken) begin
      next_inService = next_inService | (4'h1 << offerLevel); // R4 R6
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inService <= 4'h0;
    end else begin
      inService <= next_inService;
    end
  end

  // ==========================================================
  // hardware flag clear
  // level-triggered externals stay set; the peripheral owns those flags
  always_comb begin
    next_clear = 7'h00;
    if (taken) begin
      case (offerSrc)
        3'(BIT_TIMER0): next_clear[BIT_TIMER0] = 1'b1; // R9
        3'(BIT_TIMER1): next_clear[BIT_TIMER1] = 1'b1; // R9
        3'(BIT_EXT0): next_clear[BIT_EXT0] = ext0EdgeMode; // R9
        3'(BIT_EXT1): next_clear[BIT_EXT1] = ext1EdgeMode; // R9
        default: next_clear = 7'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagClear <= 7'h00;
    end else begin
      flagClear <= next_clear;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ack_sets_level_a: assert property ( // R4
    taken |=> inService[$past(offerLevel)])
    else $error("acknowledged level not marked in service");

  offer_above_service_a: assert property ( // R5
    $rose(irqReq) |-> (inService == 4'h0 || offerLevel > topLevel(inService)))
    else $error("offer not above the level in service");

  return_unwinds_a: assert property ( // R7
    (irqReturn && !taken) |=> inService == ($past(inService) & ~topOneHot($past(inService))))
    else $error("return did not close the top level");

  vector_shape_a: assert property ( // R8
    irqReq |-> (irqVector[2:0] == 3'h3 && irqVector[7:6] == 2'h0
                && irqVector == VEC_TABLE[offerSrc]))
    else $error("vector does not match offered source");

  vector_hold_a: assert property ( // R8
    (irqReq && !irqAck) |=> (irqReq && $stable(irqVector)))
    else $error("offer changed before acknowledge");

  clear_cause_a: assert property ( // R9
    (flagClear != 7'h00) |-> ($past(taken) && $onehot(flagClear)))
    else $error("flag clear without acknowledge");

  clear_never_a: assert property ( // R9
    flagClear[BIT_SERIAL] == 1'b0 && flagClear[BIT_TIMER2] == 1'b0
    && flagClear[BIT_CA] == 1'b0)
    else $error("cleared a flag that software owns");

  global_off_a: assert property ( // R10
    !$past(interruptEnableReg[BIT_GLOBAL]) |-> !arb.winValid)
    else $error("request passed with global enable off");

  reserved_zero_a: assert property ( // R12
    priorityLowReg[7] == 1'b0 && priorityHighReg[7] == 1'b0)
    else $error("reserved priority bit set");

  no_ca_source_a: assert property ( // R1
    !HAS_CA |-> !(irqReq && offerSrc == 3'(BIT_CA)))
    else $error("counter array source on a six source variant");

  apb_ready_a: assert property ( // R2
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("apb answer timing broken");

  level_map_a: assert property ( // R3
    (arb.winValid && $stable(priorityHighReg) && $stable(priorityLowReg))
    |-> arb.winLevel == levelOf(priorityHighReg[arb.winSrc], priorityLowReg[arb.winSrc]))
    else $error("winner level does not match its priority bits");

  enable_gate_a: assert property ( // R11
    (arb.winValid && $stable(interruptEnableReg))
    |-> (interruptEnableReg[arb.winSrc] && interruptEnableReg[BIT_GLOBAL]))
    else $error("winner not enabled");

  win_pending_a: assert property ( // R4
    (arb.winValid && $stable(reqFlags)) |-> reqFlags[arb.winSrc])
    else $error("winner has no request");

  global_block_a: assert property ( // R10
    !interruptEnableReg[BIT_GLOBAL] |-> arb.pend == 7'h00)
    else $error("request pending with global enable off");

  offer_from_win_a: assert property ( // R4
    $rose(irqReq) |-> ($past(arb.winValid) && offerSrc == $past(arb.winSrc)
                       && offerLevel == $past(arb.winLevel)))
    else $error("offer not taken from the arbiter");

  ack_above_a: assert property ( // R6
    taken |-> (inService == 4'h0 || offerLevel > topLevel(inService)))
    else $error("acknowledged level not above the level in service");

  ack_drops_a: assert property ( // R4
    taken |=> !irqReq)
    else $error("offer still up after acknowledge");

  settle_order_a: assert property ( // R5
    taken |=> (state == ST_SETTLE_A ##1 state == ST_SETTLE_B ##1 state == ST_IDLE))
    else $error("settle sequence broken");

  offer_gap_a: assert property ( // R5
    taken |=> (!irqReq) [*3])
    else $error("new offer inside the settle time");

  level_from_ack_a: assert property ( // R6
    ((inService & ~$past(inService)) != 4'h0) |-> $past(taken))
    else $error("level marked in service without acknowledge");

  clear_pulse_a: assert property ( // R9
    (flagClear != 7'h00) |=> flagClear == 7'h00)
    else $error("flag clear longer than one cycle");

  clear_timer0_a: assert property ( // R9
    (taken && offerSrc == 3'(BIT_TIMER0)) |=> flagClear[BIT_TIMER0])
    else $error("timer 0 flag not cleared");

  clear_timer1_a: assert property ( // R9
    (taken && offerSrc == 3'(BIT_TIMER1)) |=> flagClear[BIT_TIMER1])
    else $error("timer 1 flag not cleared");

  clear_ext0_a: assert property ( // R9
    (taken && offerSrc == 3'(BIT_EXT0)) |=> flagClear[BIT_EXT0] == $past(ext0EdgeMode))
    else $error("external 0 clear does not follow its mode");

  clear_ext1_a: assert property ( // R9
    (taken && offerSrc == 3'(BIT_EXT1)) |=> flagClear[BIT_EXT1] == $past(ext1EdgeMode))
    else $error("external 1 clear does not follow its mode");

  write_enable_a: assert property ( // R11
    (writeNow && paddr == ADDR_ENABLE)
    |=> interruptEnableReg == ($past(pwdata[7:0]) & (implMask | 8'h80)))
    else $error("enable register write lost");

  write_high_a: assert property ( // R2
    (writeNow && paddr == ADDR_PRIO_HIGH) |=> priorityHighReg == ($past(pwdata[7:0]) & implMask))
    else $error("high priority write lost");

  write_low_a: assert property ( // R12
    (writeNow && paddr == ADDR_PRIO_LOW) |=> priorityLowReg == ($past(pwdata[7:0]) & implMask))
    else $error("low priority write lost");

  hold_regs_a: assert property ( // R2
    !writeNow
    |=> ($stable(interruptEnableReg) && $stable(priorityHighReg) && $stable(priorityLowReg)))
    else $error("register changed without a write");

  err_ready_a: assert property ( // R2
    pslverr |-> pready)
    else $error("error answer without ready");

  rdata_upper_a: assert property ( // R2
    (pready && !pwrite && paddr != ADDR_STATUS) |-> prdata[31:8] == 24'h000000)
    else $error("register read upper bits not zero");

  status_read_a: assert property ( // R7
    (pready && !pwrite && paddr == ADDR_STATUS)
    |-> (prdata[3:0] == $past(inService) && prdata[4] == $past(irqReq)))
    else $error("status read does not show service levels");

  ca_masked_a: assert property ( // R1
    !HAS_CA
    |-> !(interruptEnableReg[BIT_CA] || priorityHighReg[BIT_CA] || priorityLowReg[BIT_CA]))
    else $error("counter array bit set on a six source variant");

  full_nest_c: cover property (inService == 4'hf);
  preempt_c: cover property (inService != 4'h0 ##[1:20] taken);
  return_c: cover property (inService[3] && irqReturn ##1 inService[0]);
  edge_clear_c: cover property (flagClear[BIT_EXT0]);
endmodule

//--- pkg/flipc_pkg.sv
// Purpose: constants and types of the four level interrupt priority controller
// Assumes: sources are numbered in enable register bit order
// Notes: register byte address is four times the register index
// Contract
// R1 - seven sources, six without counter array
// R2 - enable, low and high priority registers
// R3 - high:low bit pair forms level 0 to 3
// R4 - dispatch when nothing equal or higher serviced
// R5 - equal or higher in service keeps request pending
// R6 - higher level preempts lower, four deep nesting
// R7 - interrupted lower service resumes after return
// R8 - fixed polling order with fixed vectors
// R9 - hardware clears timer and edge flags; code clears the timer 0, timer 1 and edge-mode external flags, never timer 2
// R10 - global enable bit gates every source
// R11 - enable register bit layout, one enables
// R12 - low priority layout, bit 7 reserved
// R13 - same level ties go by polling order
package flipc_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_SRC = 7;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ==========================================================
  // register indices and byte addresses
  localparam logic [9:0] IDX_ENABLE = 10'h0a8;
  localparam logic [9:0] IDX_PRIO_HIGH = 10'h0b7;
  localparam logic [9:0] IDX_PRIO_LOW = 10'h0b8;
  localparam logic [9:0] IDX_STATUS = 10'h0c0;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO_HIGH = {IDX_PRIO_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO_LOW = {IDX_PRIO_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // ==========================================================
  // field positions
  localparam int BIT_EXT0 = 0;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_CA = 6;
  localparam int BIT_GLOBAL = 7;
  localparam int STAT_OFFER = 4;
  localparam int STAT_SRC_LSB = 8;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  // ==========================================================
  // types and tables
  typedef logic [2:0] flipc_src_t;
  typedef logic [1:0] flipc_level_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFER = 2'b01,
    ST_SETTLE_A = 2'b11,
    ST_SETTLE_B = 2'b10
  } flipc_state_t;
  localparam logic [7:0] VEC_TABLE [0:NUM_SRC-1] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
    8'h2b, 8'h33};
  localparam flipc_src_t POLL_ORDER [0:NUM_SRC-1] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6,
    3'h4, 3'h5};
  // ==========================================================
  // functions
  function automatic flipc_level_t levelOf(input logic hi, input logic lo);
    levelOf = {hi, lo};
  endfunction
  function automatic flipc_level_t topLevel(input logic [3:0] inService);
    topLevel = inService[3] ? 2'h3 : inService[2] ? 2'h2 : inService[1] ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [3:0] topOneHot(input logic [3:0] inService);
    topOneHot = (inService == 4'h0) ? 4'h0 : (4'h1 << topLevel(inService));
  endfunction
endpackage

//--- pkg/flipc_arb_if.sv
// Purpose: carries requests and the selected winner between controller and arbiter
// Assumes: one clock domain
// Notes: request side is combinational, winner side is registered in the arbiter
interface flipc_arb_if;
  logic [6:0] pend;
  logic [6:0] prioHigh;
  logic [6:0] prioLow;
  logic [3:0] inService;
  logic winValid;
  logic [2:0] winSrc;
  logic [1:0] winLevel;
  modport arb (input pend, input prioHigh, input prioLow, input inService,
    output winValid, output winSrc, output winLevel);
  modport ctl (output pend, output prioHigh, output prioLow, output inService,
    input winValid, input winSrc, input winLevel);
endinterface

//--- design/flipc_arbiter.sv
// Purpose: picks the pending source that may be dispatched now
// Assumes: pend is already gated by the enables
// Notes: result is registered, one cycle behind its inputs
module flipc_arbiter (
  input wire logic clk,
  input wire logic reset_n,
  flipc_arb_if.arb arb
);
  import flipc_pkg::*;

  logic next_found;
  flipc_src_t next_src;
  flipc_level_t next_level;
  flipc_src_t s;

  // ==========================================================
  // search
  always_comb begin
    next_found = 1'b0;
    next_src = 3'h0;
    next_level = 2'h0;
    s = 3'h0;
    for (int lv = 3; lv >= 0; lv--) begin
      for (int p = 0; p < NUM_SRC; p++) begin
        s = POLL_ORDER[p]; // R8
        if (!next_found && arb.pend[s]
            && levelOf(arb.prioHigh[s], arb.prioLow[s]) == flipc_level_t'(lv) // R3
            && (arb.inService == 4'h0
                || flipc_level_t'(lv) > topLevel(arb.inService))) begin // R4 R5 R6
          next_found = 1'b1; // R13
          next_src = s;
          next_level = flipc_level_t'(lv);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arb.winValid <= 1'b0;
      arb.winSrc <= 3'h0;
      arb.winLevel <= 2'h0;
    end else begin
      arb.winValid <= next_found;
      arb.winSrc <= next_src;
      arb.winLevel <= next_level;
    end
  end

  // ==========================================================
  // checks
  preempt_only_higher_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
    arb.winValid |-> ($past(arb.inService) == 4'h0
                      || arb.winLevel > topLevel($past(arb.inService))))
    else $error("winner not above the level in service");
endmodule

//--- testbench/flipc_core_model.sv
// Purpose: stand-in for the core sequencer and the request flags of the peripherals
// Assumes: flags are levels held until a hardware or software clear
// Notes: ack comes ackDelay cycles into an offer, so prompt and slow cores both appear
module flipc_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic irqReq,
  input wire logic [7:0] irqVector,
  input wire logic [6:0] flagClear,
  input wire logic [6:0] setReq,
  input wire logic [6:0] swClr,
  input wire logic retCmd,
  input wire logic [3:0] ackDelay,
  output logic irqAck,
  output logic irqReturn,
  output logic [6:0] reqFlags,
  output logic [6:0] clrSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] vecs[$];
  logic [3:0] cnt;
  // ==========================================================
  // core and peripherals
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqAck <= 1'b0;
      irqReturn <= 1'b0;
      reqFlags <= 7'h00;
      clrSeen <= 7'h00;
      cnt <= 4'h0;
    end else begin
      irqAck <= 1'b0;
      irqReturn <= retCmd;
      // ack only once per offer, vector taken with it
      if (irqReq && !irqAck) begin
        if (cnt == ackDelay) begin
          irqAck <= 1'b1;
          cnt <= 4'h0;
          vecs.push_back(irqVector);
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
      reqFlags <= (reqFlags | setReq) & ~flagClear & ~swClr;
      clrSeen <= clrSeen | flagClear;
    end
  end
endmodule

//--- testbench/four_level_irq_priority_ctrl_test.sv
// Purpose: register and nested dispatch tests of the interrupt controller
// Assumes: zero wait state apb slave, status register holds in-service levels
// Notes: vectors are compared in the order the core took them
`define CHK(n, e, a) begin cmpCount++; if ((a) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, a); miscompares++; end end

module four_level_irq_priority_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import flipc_pkg::*;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, retCmd = 0;
  logic ext0EdgeMode = 1, ext1EdgeMode = 0, pready, pslverr, err;
  logic irqReq, irqAck, irqReturn;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, ackDelay = 4'h0;
  logic [6:0] reqFlags, flagClear, clrSeen, setReq = '0, swClr = '0;
  logic [7:0] irqVector, got;
  logic [7:0] expV [0:6] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h33, 8'h23, 8'h2b};
  int srcBit [0:6] = '{0, 1, 2, 3, 6, 4, 5};
  logic [11:0] regs [0:2] = '{ADDR_ENABLE, ADDR_PRIO_HIGH, ADDR_PRIO_LOW};
  logic [31:0] wrExp [0:2] = '{32'hff, 32'h7f, 32'h7f};
  logic [31:0] wrExp6 [0:2] = '{32'hbf, 32'h3f, 32'h3f};
  logic [31:0] prdata6, rd6;
  int miscompares = 0, cmpCount = 0;

  always #5 clk = ~clk;

  flipc_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reqFlags, .ext0EdgeMode, .ext1EdgeMode, .irqAck,
    .irqReturn, .irqReq, .irqVector, .flagClear);
  // six source variant shares the bus; only its register masking is checked
  flipc_top #(.HAS_CA(1'b0)) uut_six (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata(prdata6), .pready(), .pslverr(), .reqFlags, .ext0EdgeMode,
    .ext1EdgeMode, .irqAck(1'b0), .irqReturn(1'b0), .irqReq(), .irqVector(), .flagClear());
  flipc_core_model cm (.clk, .reset_n, .irqReq, .irqVector, .flagClear, .setReq,
    .swClr, .retCmd, .ackDelay, .irqAck, .irqReturn, .reqFlags, .clrSeen);

  task summarize;
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // bus and core helpers
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    rd6 = prdata6;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input logic [6:0] s, input logic [6:0] c, input logic r);
    @(posedge clk);
    setReq <= s;
    swClr <= c;
    retCmd <= r;
    @(posedge clk);
    setReq <= '0;
    swClr <= '0;
    retCmd <= 1'b0;
  endtask

  task waitVec(input logic [7:0] v);
    int n;
    n = 0;
    while (cm.vecs.size() == 0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n == 60) begin
      miscompares++;
      summarize();
    end
    got = cm.vecs.pop_front();
    `CHK("vector", v, got)
  endtask

  // holding back shows only over a window, ten cycles exceeds any offer latency
  task quiet;
    repeat (10) @(posedge clk);
    `CHK("no offer", 1'b1, (cm.vecs.size() == 0 && irqReq === 1'b0))
  endtask

  task status(input logic [3:0] e);
    apb(1'b0, ADDR_STATUS, '0);
    `CHK("in service", e, rd[3:0])
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, regs[i], '0);
      `CHK("reset value", 32'h0, rd)
      apb(1'b1, regs[i], 32'hff);
      apb(1'b0, regs[i], '0);
      `CHK("register", wrExp[i], rd)
      `CHK("six source register", wrExp6[i], rd6)
    end
    apb(1'b1, ADDR_ENABLE, '0, 4'h0);
    apb(1'b0, ADDR_ENABLE, '0);
    `CHK("masked write", 32'hff, rd)
    apb(1'b0, 12'h004, '0);
    `CHK("slverr", 1'b1, err)
    $display("test registers done");
    pulse(7'h7f, '0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      waitVec(expV[i]);
      pulse('0, 7'(1 << srcBit[i]), 1'b1);
    end
    `CHK("hw clears", 7'h0b, clrSeen)
    $display("test polling order done");
    apb(1'b1, ADDR_PRIO_HIGH, 32'h0c);
    apb(1'b1, ADDR_PRIO_LOW, 32'h04);
    apb(1'b1, ADDR_ENABLE, 32'h7f);
    pulse(7'h02, '0, 1'b0);
    quiet();
    apb(1'b1, ADDR_ENABLE, 32'hff);
    waitVec(8'h0b);
    $display("test global gate done");
    ackDelay <= 4'h3;
    pulse(7'h01, '0, 1'b0);
    quiet();
    pulse(7'h04, '0, 1'b0);
    waitVec(8'h13);
    status(4'h9);
    pulse(7'h08, '0, 1'b0);
    quiet();
    pulse('0, 7'h04, 1'b1);
    waitVec(8'h1b);
    status(4'h5);
    pulse('0, '0, 1'b1);
    status(4'h1);
    quiet();
    pulse('0, '0, 1'b1);
    waitVec(8'h03);
    pulse('0, 7'h01, 1'b1);
    status(4'h0);
    $display("test nesting done");
    summarize();
  end
endmodule
